// *** logic/sdcmd_pkg.sv ***
// shared constants and types for the command-issue block
package sdcmd_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  OFF_CLOCK   = 8'h08;
  localparam logic [7:0]  OFF_ARG     = 8'h28;
  localparam logic [7:0]  OFF_CMD     = 8'h2c;
  localparam logic [7:0]  OFF_EVENT   = 8'h44;
  localparam logic [7:0]  OFF_STATE   = 8'h48;
  localparam logic [31:0] CMD_RESET   = 32'h0000_0000;
  localparam logic [31:0] ARG_RESET   = 32'h0000_0000;
  localparam logic [31:0] CLOCK_RESET = 32'h0001_0000;
  localparam logic [31:0] CMD_MASK    = 32'h8020_ffff;
  localparam logic [31:0] CLOCK_MASK  = 32'h0001_00ff;
  localparam logic [31:0] EVENT_MASK  = 32'h0000_5144;

  // ----------------------------------------------------------------
  // event bit positions
  // ----------------------------------------------------------------
  localparam int EV_CMD_DONE   = 2;
  localparam int EV_REPLY_CRC  = 6;
  localparam int EV_REPLY_TO   = 8;
  localparam int EV_LOCKED_WR  = 12;
  localparam int EV_AUTO_DONE  = 14;

  // ----------------------------------------------------------------
  // frame and timing counts in card clock ticks, plus the stop index and crc7 polynomial
  // ----------------------------------------------------------------
  localparam logic [7:0] INIT_CLOCKS  = 8'd80;
  localparam logic [7:0] CMD_BITS     = 8'd48;
  localparam logic [7:0] SHORT_BITS   = 8'd48;
  localparam logic [7:0] LONG_BITS    = 8'd136;
  localparam logic [7:0] REPLY_WAIT   = 8'd64;
  localparam logic [5:0] STOP_INDEX   = 6'h0c;
  localparam logic [6:0] CRC7_POLY    = 7'h09;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       go;
    logic [8:0] rsvHigh;
    logic       clockOnly;
    logic [4:0] rsvMid;
    logic       initFirst;
    logic       halt;
    logic       waitPrior;
    logic       autoHalt;
    logic       stream;
    logic       write;
    logic       dataPhase;
    logic       crcCheck;
    logic       longReply;
    logic       replyWanted;
    logic [5:0] index;
  } cmd_fields_t;

  typedef struct packed {
    logic [14:0] rsvHigh;
    logic        enable;
    logic [7:0]  rsvLow;
    logic [7:0]  divisor;
  } clock_cfg_t;

  typedef struct packed {
    logic start;
    logic write;
    logic stream;
    logic abort;
  } data_ctl_t;

  typedef enum logic [2:0] {
    PH_IDLE  = 3'b000,
    PH_WAIT  = 3'b001,
    PH_PRE   = 3'b011,
    PH_SEND  = 3'b010,
    PH_WRESP = 3'b110,
    PH_RECV  = 3'b111,
    PH_FIN   = 3'b101
  } phase_t;

endpackage : sdcmd_pkg

// *** logic/card_clk_div.sv ***
// card clock divider with settings loaded only on request
`timescale 1ns/1ps
module card_clk_div (
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  // settings transfer
  input  wire logic                  load,
  input  wire sdcmd_pkg::clock_cfg_t cfg,
  // card timing
  output logic                       tick,
  output logic                       cardClk
);
  sdcmd_pkg::clock_cfg_t cfgReg, cfgNext;
  logic [7:0]            cntReg, cntNext;
  logic                  clkReg, clkNext;

  // tick marks the falling card clock edge, where the line may change
  always_comb begin
    cfgNext = load ? cfg : cfgReg;
    cntNext = cntReg;
    clkNext = clkReg;
    tick    = 1'b0;
    if (!cfgReg.enable) begin
      cntNext = 8'h00;
      clkNext = 1'b0;
    end else if (cntReg == cfgReg.divisor) begin
      cntNext = 8'h00;
      clkNext = !clkReg;
      tick    = clkReg;
    end else begin
      cntNext = cntReg + 8'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cfgReg <= sdcmd_pkg::clock_cfg_t'(sdcmd_pkg::CLOCK_RESET);
      cntReg <= 8'h00;
      clkReg <= 1'b0;
    end else begin
      cfgReg <= cfgNext;
      cntReg <= cntNext;
      clkReg <= clkNext;
    end
  end

  assign cardClk = clkReg;
endmodule : card_clk_div

// *** logic/sd_cmd_issue.sv ***
// command-issue register and card command sequencer
//
// Chosen here: the address map and the APB slave port.
`timescale 1ns/1ps
module sd_cmd_issue (
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  // card command line
  output logic                       cardClk,
  output logic                       cmdOut,
  output logic                       cmdOe,
  input  wire logic                  cmdIn,
  // data path
  output sdcmd_pkg::data_ctl_t       dataCtl,
  input  wire logic                  dataBusy,
  // reply
  output logic [135:0]               replyData,
  output logic                       replyValid
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [6:0] crc7(input logic [119:0] bits, input int n);
    logic [6:0] c;
    logic       fb;
    c = 7'h00;
    for (int i = 0; i < 120; i++) begin
      if (i < n) begin
        fb = bits[119-i] ^ c[6];
        c  = {c[5:0], 1'b0} ^ (fb ? sdcmd_pkg::CRC7_POLY : 7'h00);
      end
    end
    return c;
  endfunction : crc7

  function automatic logic [47:0] frame(input logic [5:0] idx, input logic [31:0] arg);
    logic [39:0] p;
    p = {2'b01, idx, arg};
    return {p, crc7({p, 80'h0}, 40), 1'b1};
  endfunction : frame

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  sdcmd_pkg::cmd_fields_t cmdReg, cmdNext, actReg, actNext;
  sdcmd_pkg::clock_cfg_t  clockReg, clockNext;
  sdcmd_pkg::phase_t      phReg, phNext;
  sdcmd_pkg::data_ctl_t   ctlReg, ctlNext;
  logic [31:0]            argReg, argNext, eventReg, eventNext;
  logic [31:0]            rdReg, rdNext, evSet, evClr;
  logic [7:0]             bitReg, bitNext, waitReg, waitNext, lastBit;
  logic [47:0]            txReg, txNext;
  logic [135:0]           rxReg, rxNext, rxShift;
  logic                   autoReg, autoNext, validReg, validNext;
  logic                   tick, loadClock, take, wr, mapped, crcOk;
  logic                   setDone, setAuto, setCrc, setTimeout;

  card_clk_div u_div (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .load    (loadClock),
    .cfg     (clockReg),
    .tick    (tick),
    .cardClk (cardClk)
  );

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  assign wr      = psel && penable && pwrite;
  assign mapped  = paddr inside {sdcmd_pkg::OFF_CLOCK, sdcmd_pkg::OFF_ARG, sdcmd_pkg::OFF_CMD,
                                 sdcmd_pkg::OFF_EVENT, sdcmd_pkg::OFF_STATE};
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = rdReg;
  assign take    = (phReg == sdcmd_pkg::PH_IDLE) && cmdReg.go;

  always_comb begin
    cmdNext   = cmdReg;
    argNext   = argReg;
    clockNext = clockReg;
    evSet     = 32'h0;
    evClr     = 32'h0;
    rdNext    = rdReg;
    if (take)
      cmdNext.go = 1'b0;
    if (wr) begin
      unique case (paddr)
        sdcmd_pkg::OFF_CMD, sdcmd_pkg::OFF_ARG: begin
          // a busy command register is locked, the attempt is flagged
          if (cmdReg.go)
            evSet[sdcmd_pkg::EV_LOCKED_WR] = 1'b1;
          else if (paddr == sdcmd_pkg::OFF_CMD)
            cmdNext = sdcmd_pkg::cmd_fields_t'(pwdata & sdcmd_pkg::CMD_MASK);
          else
            argNext = pwdata;
        end
        sdcmd_pkg::OFF_CLOCK: clockNext = sdcmd_pkg::clock_cfg_t'(pwdata & sdcmd_pkg::CLOCK_MASK);
        sdcmd_pkg::OFF_EVENT: evClr = pwdata;
        default: ;
      endcase
    end
    if (psel && !penable) begin
      unique case (paddr)
        sdcmd_pkg::OFF_CMD:   rdNext = cmdReg;
        sdcmd_pkg::OFF_ARG:   rdNext = argReg;
        sdcmd_pkg::OFF_CLOCK: rdNext = clockReg;
        sdcmd_pkg::OFF_EVENT: rdNext = eventReg;
        sdcmd_pkg::OFF_STATE: rdNext = {28'h0, autoReg, phReg};
        default:              rdNext = 32'h0;
      endcase
    end
    evSet[sdcmd_pkg::EV_CMD_DONE]  = setDone;
    evSet[sdcmd_pkg::EV_AUTO_DONE] = setAuto;
    evSet[sdcmd_pkg::EV_REPLY_CRC] = setCrc;
    evSet[sdcmd_pkg::EV_REPLY_TO]  = setTimeout;
    // set wins over a clear in the same cycle
    eventNext = ((eventReg & ~evClr) | evSet) & sdcmd_pkg::EVENT_MASK;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cmdReg   <= sdcmd_pkg::cmd_fields_t'(sdcmd_pkg::CMD_RESET);
      argReg   <= sdcmd_pkg::ARG_RESET;
      clockReg <= sdcmd_pkg::clock_cfg_t'(sdcmd_pkg::CLOCK_RESET);
      eventReg <= 32'h0;
      rdReg    <= 32'h0;
    end else begin
      cmdReg   <= cmdNext;
      argReg   <= argNext;
      clockReg <= clockNext;
      eventReg <= eventNext;
      rdReg    <= rdNext;
    end
  end

  // ----------------------------------------------------------------
  // command sequencer
  // ----------------------------------------------------------------
  // reply length
  assign lastBit = (actReg.longReply ? sdcmd_pkg::LONG_BITS : sdcmd_pkg::SHORT_BITS) - 8'd1;
  // crc covers the payload ahead of the crc field
  // taken from the shifter input, not rxNext, so no loop through the sequencer process
  assign rxShift = {rxReg[134:0], cmdIn};
  assign crcOk   = actReg.longReply ? (crc7(rxShift[127:8], 120) == rxShift[7:1])
                                    : (crc7({rxShift[47:8], 80'h0}, 40) == rxShift[7:1]);

  always_comb begin
    phNext     = phReg;
    actNext    = actReg;
    autoNext   = autoReg;
    bitNext    = bitReg;
    waitNext   = waitReg;
    txNext     = txReg;
    rxNext     = rxReg;
    ctlNext    = '0;
    validNext  = 1'b0;
    loadClock  = 1'b0;
    setDone    = 1'b0;
    setAuto    = 1'b0;
    setCrc     = 1'b0;
    setTimeout = 1'b0;
    unique case (phReg)
      sdcmd_pkg::PH_IDLE: begin
        if (cmdReg.go) begin
          // settings move only, no frame and no done event
          if (cmdReg.clockOnly) begin
            loadClock = 1'b1;
          end else begin
            actNext  = cmdReg;
            autoNext = 1'b0;
            bitNext  = 8'h00;
            txNext   = frame(cmdReg.index, argReg);
            // hold only while a data transfer runs
            if (cmdReg.waitPrior && dataBusy)
              phNext = sdcmd_pkg::PH_WAIT;
            else if (cmdReg.initFirst)
              phNext = sdcmd_pkg::PH_PRE;
            else
              phNext = sdcmd_pkg::PH_SEND;
          end
        end
      end
      sdcmd_pkg::PH_WAIT: begin
        // released by the end of data
        if (!dataBusy) begin
          bitNext = 8'h00;
          phNext  = (actReg.initFirst && !autoReg) ? sdcmd_pkg::PH_PRE : sdcmd_pkg::PH_SEND;
        end
      end
      sdcmd_pkg::PH_PRE: begin
        if (tick) begin
          if (bitReg == sdcmd_pkg::INIT_CLOCKS - 8'd1) begin
            bitNext = 8'h00;
            phNext  = sdcmd_pkg::PH_SEND;
          end else begin
            bitNext = bitReg + 8'd1;
          end
        end
      end
      sdcmd_pkg::PH_SEND: begin
        if (tick) begin
          txNext = {txReg[46:0], 1'b1};
          if (bitReg == sdcmd_pkg::CMD_BITS - 8'd1) begin
            bitNext  = 8'h00;
            waitNext = 8'h00;
            // abort the data path after a stop command
            ctlNext.abort = actReg.halt;
            // start data phase with direction and kind
            ctlNext.start  = actReg.dataPhase;
            ctlNext.write  = actReg.write;
            ctlNext.stream = actReg.stream;
            // wait for a reply only when wanted
            phNext = actReg.replyWanted ? sdcmd_pkg::PH_WRESP : sdcmd_pkg::PH_FIN;
          end else begin
            bitNext = bitReg + 8'd1;
          end
        end
      end
      sdcmd_pkg::PH_WRESP: begin
        if (tick) begin
          if (!cmdIn) begin
            rxNext  = 136'h0;
            bitNext = 8'd1;
            phNext  = sdcmd_pkg::PH_RECV;
          end else if (waitReg == sdcmd_pkg::REPLY_WAIT - 8'd1) begin
            setTimeout = 1'b1;
            phNext     = sdcmd_pkg::PH_FIN;
          end else begin
            waitNext = waitReg + 8'd1;
          end
        end
      end
      sdcmd_pkg::PH_RECV: begin
        if (tick) begin
          rxNext = rxShift;
          if (bitReg == lastBit) begin
            validNext = 1'b1;
            setCrc    = actReg.crcCheck && !crcOk;
            phNext    = sdcmd_pkg::PH_FIN;
          end else begin
            bitNext = bitReg + 8'd1;
          end
        end
      end
      sdcmd_pkg::PH_FIN: begin
        setDone = !autoReg;
        setAuto = autoReg;
        // stop after data, only for data commands
        if (actReg.dataPhase && actReg.autoHalt && !autoReg) begin
          autoNext = 1'b1;
          actNext  = sdcmd_pkg::cmd_fields_t'(sdcmd_pkg::CMD_RESET);
          actNext.halt        = 1'b1;
          actNext.replyWanted = 1'b1;
          actNext.crcCheck    = 1'b1;
          actNext.index       = sdcmd_pkg::STOP_INDEX;
          txNext   = frame(sdcmd_pkg::STOP_INDEX, 32'h0);
          phNext   = sdcmd_pkg::PH_WAIT;
        end else begin
          autoNext = 1'b0;
          phNext   = sdcmd_pkg::PH_IDLE;
        end
      end
      default: phNext = sdcmd_pkg::PH_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      phReg    <= sdcmd_pkg::PH_IDLE;
      actReg   <= sdcmd_pkg::cmd_fields_t'(sdcmd_pkg::CMD_RESET);
      autoReg  <= 1'b0;
      bitReg   <= 8'h00;
      waitReg  <= 8'h00;
      txReg    <= 48'h0;
      rxReg    <= 136'h0;
      ctlReg   <= '0;
      validReg <= 1'b0;
    end else begin
      phReg    <= phNext;
      actReg   <= actNext;
      autoReg  <= autoNext;
      bitReg   <= bitNext;
      waitReg  <= waitNext;
      txReg    <= txNext;
      rxReg    <= rxNext;
      ctlReg   <= ctlNext;
      validReg <= validNext;
    end
  end

  // preamble drives a steady high; the frame comes from the shifter flop
  assign cmdOe      = (phReg == sdcmd_pkg::PH_PRE) || (phReg == sdcmd_pkg::PH_SEND);
  assign cmdOut     = (phReg == sdcmd_pkg::PH_PRE) || txReg[47];
  assign dataCtl    = ctlReg;
  assign replyData  = rxReg;
  assign replyValid = validReg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_go_self_clear: assert property (take |=> !cmdReg.go)
    else $error("go bit not cleared after take");
  a_clkonly_quiet: assert property (take && cmdReg.clockOnly |=> phReg == sdcmd_pkg::PH_IDLE && !cmdOe)
    else $error("settings-only request started a frame");
  a_clkonly_nodone: assert property (take && cmdReg.clockOnly |-> ##1 !setDone ##1 !setDone)
    else $error("done event after settings-only request");
  a_preamble_high: assert property (phReg == sdcmd_pkg::PH_PRE |-> cmdOe && cmdOut)
    else $error("preamble line not driven high");
  a_preamble_skip: assert property (take && !cmdReg.clockOnly && !cmdReg.initFirst && !dataBusy
                                    |=> phReg == sdcmd_pkg::PH_SEND)
    else $error("preamble not skipped");
  a_wait_hold: assert property (phReg == sdcmd_pkg::PH_WAIT && dataBusy |=> phReg == sdcmd_pkg::PH_WAIT)
    else $error("command left wait while data busy");
  a_halt_abort: assert property (phReg == sdcmd_pkg::PH_SEND && tick && bitReg == 8'd47
                                 |=> dataCtl.abort == $past(actReg.halt))
    else $error("abort pulse does not follow halt");
  a_data_dir: assert property (phReg == sdcmd_pkg::PH_SEND && tick && bitReg == 8'd47 && actReg.dataPhase
                               |=> dataCtl.start && dataCtl.write == $past(actReg.write)
                                   && dataCtl.stream == $past(actReg.stream))
    else $error("data start or direction wrong");
  a_no_reply: assert property (phReg == sdcmd_pkg::PH_SEND && tick && bitReg == 8'd47 && !actReg.replyWanted
                               |=> phReg == sdcmd_pkg::PH_FIN)
    else $error("reply awaited when not wanted");
  a_reply_len: assert property (phReg == sdcmd_pkg::PH_RECV && tick && bitReg == 8'd47 && actReg.longReply
                                |=> phReg == sdcmd_pkg::PH_RECV)
    else $error("long reply cut short");
  a_crc_gate: assert property (setCrc |-> actReg.crcCheck)
    else $error("crc flagged with check disabled");
  a_index_frame: assert property (take && !cmdReg.clockOnly |=> txReg[45:40] == $past(cmdReg.index))
    else $error("index not in frame");
  a_auto_stop: assert property (phReg == sdcmd_pkg::PH_FIN && actReg.dataPhase && actReg.autoHalt && !autoReg
                                |=> autoReg && actReg.index == sdcmd_pkg::STOP_INDEX)
    else $error("auto stop not scheduled");

  c_preamble: cover property (phReg == sdcmd_pkg::PH_PRE ##1 phReg == sdcmd_pkg::PH_SEND);
  c_auto_done: cover property (setAuto);
  c_long_reply: cover property (validReg && actReg.longReply);
  c_clock_only: cover property (loadClock);
endmodule : sd_cmd_issue

// *** test/sd_card_model.sv ***
// card model: takes command frames and answers on the command line
`timescale 1ns/1ps
module sd_card_model (
  // clocks
  input  wire logic         mclk,
  input  wire logic         cardClk,
  // command line
  input  wire logic         cmdOut,
  input  wire logic         cmdOe,
  output logic              cmdIn,
  // scenario control
  input  wire logic [1:0]   replyKind,
  input  wire logic         badCrc,
  input  wire logic         slow,
  // observation
  output logic [47:0]       frame,
  output logic [135:0]      reply,
  output int                frameCnt,
  output int                preCnt
);
  logic cardOe;
  logic cardOut;
  int   preRun;

  function automatic logic [6:0] crc7(input logic [119:0] d, input int n);
    logic [6:0] c;
    c = 7'h00;
    for (int i = n - 1; i >= 0; i--) begin
      c = {c[5:0], 1'b0} ^ ((c[6] ^ d[i]) ? 7'h09 : 7'h00);
    end
    return c;
  endfunction : crc7

  // released line is pulled up, never left at the last value
  assign cmdIn = cmdOe ? cmdOut : (cardOe ? cardOut : 1'b1);

  // driven on the falling mclk edge, so no race with the divider flops
  task automatic answer();
    int n;
    n = (replyKind == 2'd2) ? 136 : 48;
    if (replyKind == 2'd2) begin
      reply = {2'b00, 6'h3f, {4{frame[39:10]}}, 8'h01};
      reply[7:1] = crc7(reply[127:8], 120) ^ {6'h00, badCrc};
    end else begin
      reply = {88'h0, 2'b00, frame[45:40], ~frame[39:8], 8'h01};
      reply[7:1] = crc7({80'h0, reply[47:8]}, 40) ^ {6'h00, badCrc};
    end
    repeat (slow ? 60 : 6) @(negedge mclk);
    cardOe = 1'b1;
    for (int i = n - 1; i >= 0; i--) begin
      cardOut = reply[i];
      repeat (2) @(negedge mclk);
    end
    cardOe  = 1'b0;
    cardOut = 1'b1;
  endtask : answer

  initial begin
    cardOe   = 1'b0;
    cardOut  = 1'b1;
    frame    = '0;
    reply    = '0;
    frameCnt = 0;
    preCnt   = 0;
    preRun   = 0;
    forever begin
      @(negedge mclk);
      if (cmdOe !== 1'b1) begin
        preRun = 0;
      end else if (cmdOut === 1'b1) begin
        preRun++;
      end else begin
        // one bit lasts two mclk cycles at the reset divisor
        // the first preamble bit may last one mclk or two, depending on the tick phase
        preCnt = (preRun + 1) / 2;
        for (int i = 0; i < 48; i++) begin
          frame = {frame[46:0], cmdOut};
          if (i < 47) repeat (2) @(negedge mclk);
        end
        frameCnt++;
        if (replyKind != 2'd0) answer();
      end
    end
  end
endmodule : sd_card_model

// *** test/sd_card_command_issue_control_bench.sv ***
// self-checking bench for the command-issue block
`timescale 1ns/1ps
module sd_card_command_issue_control_bench;
  logic                   mclk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic                   cardClk, cmdOut, cmdOe, cmdIn, dataBusy, replyValid, badCrc, slow, err;
  logic [7:0]             paddr;
  logic [31:0]            pwdata, prdata, rd, ev;
  logic [135:0]           replyData, reply;
  logic [47:0]            frame;
  logic [1:0]             replyKind;
  sdcmd_pkg::data_ctl_t   dataCtl, lastStart;
  sdcmd_pkg::cmd_fields_t f;
  int                     frameCnt, preCnt, failCount, nTests, cycles, starts, aborts, f0, valids;
  time                    t0;

  sd_cmd_issue sd_cmd_issue_i (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .cardClk, .cmdOut, .cmdOe, .cmdIn, .dataCtl, .dataBusy, .replyData, .replyValid);
  sd_card_model sd_card_model_i (.mclk, .cardClk, .cmdOut, .cmdOe, .cmdIn, .replyKind, .badCrc, .slow,
    .frame, .reply, .frameCnt, .preCnt);

  // ----
  // checking and bus tasks
  // ----
  task automatic closeOut();
    $display("checks %0d mismatches %0d", nTests, failCount);
    if (failCount == 0 && nTests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : closeOut

  task automatic chk(input string name, input logic [135:0] seen, input logic [135:0] exp);
    nTests++;
    if (seen !== exp) begin
      failCount++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic waitEv(input int b);
    do apb(1'b0, sdcmd_pkg::OFF_EVENT, 32'h0); while (rd[b] !== 1'b1);
    ev = rd;
    apb(1'b1, sdcmd_pkg::OFF_EVENT, 32'hffff_ffff);
  endtask : waitEv

  task automatic run(input sdcmd_pkg::cmd_fields_t c, input logic [31:0] arg, input logic [1:0] k);
    int          s0;
    int          v0;
    logic [47:0] exp;
    f0 = frameCnt;
    s0 = starts;
    v0 = valids;
    replyKind = k;
    apb(1'b1, sdcmd_pkg::OFF_ARG, arg);
    c.go = 1'b1;
    apb(1'b1, sdcmd_pkg::OFF_CMD, c);
    apb(1'b0, sdcmd_pkg::OFF_CMD, 32'h0);
    chk("go clear", rd[31], 1'b0);
    if (c.waitPrior && dataBusy) begin
      repeat (40) @(posedge mclk);
      chk("held", frameCnt - f0, 0);
      apb(1'b0, sdcmd_pkg::OFF_STATE, 32'h0);
      chk("wait phase", rd[2:0], 3'b001);
      dataBusy <= 1'b0;
    end
    waitEv(sdcmd_pkg::EV_CMD_DONE);
    exp = {2'b01, c.index, arg, 8'h01};
    exp[7:1] = sd_card_model_i.crc7({80'h0, exp[47:8]}, 40);
    chk("frame count", frameCnt - f0, 1);
    chk("frame", frame, exp);
    chk("preamble", preCnt, c.initFirst ? 80 : 0);
    chk("timeout", ev[sdcmd_pkg::EV_REPLY_TO], c.replyWanted && k == 2'd0);
    chk("crc flag", ev[sdcmd_pkg::EV_REPLY_CRC], c.replyWanted && k != 2'd0 && badCrc && c.crcCheck);
    if (c.replyWanted && k != 2'd0) chk("reply", c.longReply ? replyData : replyData[47:0],
      c.longReply ? reply : reply[47:0]);
    chk("data start", starts - s0, c.dataPhase);
    chk("reply valid", valids - v0, c.replyWanted && k != 2'd0);
    if (c.dataPhase) chk("data kind", {lastStart.write, lastStart.stream}, {c.write, c.stream});
  endtask : run

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (dataCtl.start === 1'b1) begin
      starts <= starts + 1;
      lastStart <= dataCtl;
    end
    if (dataCtl.abort === 1'b1) aborts <= aborts + 1;
    if (replyValid === 1'b1) valids <= valids + 1;
    if (cycles == 60000) begin
      failCount++;
      closeOut();
    end
  end

  // ----
  // main sequence
  // ----
  initial begin
    {rst_n, psel, penable, pwrite, dataBusy, badCrc, slow} = '0;
    {paddr, pwdata, replyKind, failCount, nTests, cycles, starts, aborts, valids} = '0;
    void'($urandom(32'h3424));
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    apb(1'b0, sdcmd_pkg::OFF_CMD, 32'h0);
    chk("cmd reset", rd, sdcmd_pkg::CMD_RESET);
    apb(1'b0, sdcmd_pkg::OFF_CLOCK, 32'h0);
    chk("clock reset", rd, sdcmd_pkg::CLOCK_RESET);
    apb(1'b0, 8'h3c, 32'h0);
    chk("unmapped", err, 1'b1);
    f = '0;
    {f.initFirst, f.replyWanted, f.crcCheck} = 3'b111;
    run(f, 32'h0, 2'd1);
    repeat (8) begin
      f = '0;
      {f.initFirst, f.dataPhase, f.write, f.stream, f.crcCheck, f.longReply, f.replyWanted, f.index} = 13'($urandom);
      {badCrc, slow} = 2'($urandom);
      run(f, $urandom, f.replyWanted ? (f.longReply ? 2'd2 : 2'd1) : 2'd0);
    end
    // silent card, then a held command released by the data path
    f = '0;
    f.replyWanted = 1'b1;
    run(f, 32'hffff_ffff, 2'd0);
    dataBusy <= 1'b1;
    f.waitPrior = 1'b1;
    // crc check left off for this reply
    run(f, 32'h1234_5678, 2'd1);
    dataBusy <= 1'b1;
    f = '0;
    // one card only, so the stop addresses the transfer's card
    {f.halt, f.index} = {1'b1, sdcmd_pkg::STOP_INDEX};
    run(f, 32'h0, 2'd0);
    chk("abort", aborts, 1);
    apb(1'b0, sdcmd_pkg::OFF_STATE, 32'h0);
    chk("idle", rd[2:0], 3'b000);
    f = '0;
    {f.dataPhase, f.autoHalt} = 2'b11;
    run(f, 32'h0000_0400, 2'd0);
    replyKind = 2'd1;
    f0 = frameCnt;
    repeat (60) @(posedge mclk);
    chk("no early stop", frameCnt - f0, 0);
    dataBusy <= 1'b0;
    waitEv(sdcmd_pkg::EV_AUTO_DONE);
    chk("auto stop", frame[45:8], {sdcmd_pkg::STOP_INDEX, 32'h0});
    // settings-only request: divisor 1, nothing sent
    f0 = frameCnt;
    apb(1'b1, sdcmd_pkg::OFF_CLOCK, 32'h0001_0001);
    f = '0;
    {f.go, f.clockOnly} = 2'b11;
    apb(1'b1, sdcmd_pkg::OFF_CMD, f);
    repeat (100) @(posedge mclk);
    apb(1'b0, sdcmd_pkg::OFF_EVENT, 32'h0);
    chk("no done", rd[sdcmd_pkg::EV_CMD_DONE], 1'b0);
    chk("no frame", frameCnt - f0, 0);
    @(posedge cardClk);
    t0 = $time;
    @(posedge cardClk);
    chk("card clock", ($time - t0) / 8, 4);
    closeOut();
  end
endmodule : sd_card_command_issue_control_bench
